//--- flash_led_control_logic.sv
// Notes on behaviour
// - Serial writes store data into the addressed control register.
// - Register mode: enable bits pick off, torch, flash or both.
// - Mode select high takes torch and flash enables from pins.
// - Delay code times 5 ms sets wait before light-up, default 0.
// - On-time code maps to 50..1000 ms of light, default 50 ms.
// - Timer enabled: wait delay, flash for on-time, then turn off.
// - Timer disabled: flash cut off after on-time as protection.
// - Direct mode: no timer sequence, flash follows the pin.
// - Direct mode: flash forced off after 500 ms held active.
// - Torch code selects 50..200 mA; direct mode uses code 3.
// - Flash code selects 400..800 mA; direct mode uses code 3.
// - Power limit bit caps flash at 400 mA; off in direct mode.
// - Start-up current limit steps 0, 0.5, 1, 1.5 then 2 A.
// - Over-temperature makes the device inactive until it clears.
// - Over-voltage stops boost switching until sense drops again.
// - Open sense pin stops boost switching.
// - Shared pin: active-low reset in register mode, flash enable in direct.
// - Shared pin: chip select in register mode, torch enable in direct.
`timescale 1ns/1ps
`default_nettype none
module flash_led_control_logic #(
    parameter int TICK_CYCLES = flash_pkg::TICK_CYCLES,
    parameter int MS_TICKS    = flash_pkg::US_PER_MS
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic       interface_mode_select_in,
    input  wire logic       reset_or_flash_pin_in,
    input  wire logic       select_or_torch_pin_in,
    input  wire logic       serial_clk_in,
    input  wire logic       serial_data_in,
    input  wire logic       overvoltage_sense_in,
    input  wire logic       open_sense_detect_in,
    input  wire logic       thermal_shutdown_in,
    output var  logic       torch_driver_on_out,
    output var  logic       flash_driver_on_out,
    output var  logic [1:0] torch_code_out,
    output var  logic [1:0] flash_code_out,
    output var  logic [2:0] current_limit_step_out,
    output var  logic       boost_switch_enable_out,
    output var  logic       device_active_out
);
    import flash_pkg::*;

    localparam int PIN_MODE = 0;
    localparam int PIN_RSTF = 1;
    localparam int PIN_SELT = 2;
    localparam int PIN_SCLK = 3;
    localparam int PIN_SDI  = 4;
    localparam int PIN_HIV  = 5;
    localparam int PIN_OPEN = 6;
    localparam int PIN_HOT  = 7;

    // Timebase
    timebase_if tb ();

    tick_gen #(
        .TICK_CYCLES (TICK_CYCLES),
        .MS_TICKS    (MS_TICKS)
    ) tick_gen_i (
        .clk_in (ref_clk_in),
        .rst_in (rst_in),
        .tb     (tb)
    );

    // Two-stage synchronisers for every pin
    logic [7:0] pins_raw;
    logic [7:0] sync_a;
    logic [7:0] sync_b;
    logic [7:0] next_sync_a;
    logic [7:0] next_sync_b;

    assign pins_raw = {thermal_shutdown_in, open_sense_detect_in, overvoltage_sense_in, serial_data_in,
                       serial_clk_in, select_or_torch_pin_in, reset_or_flash_pin_in, interface_mode_select_in};

    always_comb begin
        next_sync_a = pins_raw;
        next_sync_b = sync_a;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    logic mode_s;
    logic rstf_s;
    logic selt_s;
    logic sclk_s;
    logic sdi_s;
    logic hiv_s;
    logic open_s;
    logic hot_s;

    assign mode_s = sync_b[PIN_MODE];
    assign rstf_s = sync_b[PIN_RSTF];
    assign selt_s = sync_b[PIN_SELT];
    assign sclk_s = sync_b[PIN_SCLK];
    assign sdi_s  = sync_b[PIN_SDI];
    assign hiv_s  = sync_b[PIN_HIV];
    assign open_s = sync_b[PIN_OPEN];
    assign hot_s  = sync_b[PIN_HOT];

    // Serial write port and control registers
    logic [15:0] shift_reg;
    logic [15:0] next_shift_reg;
    logic [4:0]  bit_cnt;
    logic [4:0]  next_bit_cnt;
    logic        sclk_prev;
    logic        next_sclk_prev;
    logic        cs_prev;
    logic        next_cs_prev;
    logic [7:0]  en_reg;
    logic [7:0]  next_en_reg;
    logic [7:0]  tm_reg;
    logic [7:0]  next_tm_reg;
    logic [7:0]  cur_reg;
    logic [7:0]  next_cur_reg;
    logic        pin_reset;
    logic        cs_act;
    logic        commit;

    assign pin_reset = !mode_s && !rstf_s;
    assign cs_act    = !mode_s && !selt_s;
    assign commit    = cs_prev && !cs_act && (bit_cnt == 5'(FRAME_BITS));

    always_comb begin
        next_shift_reg = shift_reg;
        next_bit_cnt   = bit_cnt;
        next_sclk_prev = sclk_s;
        next_cs_prev   = cs_act;
        next_en_reg    = en_reg;
        next_tm_reg    = tm_reg;
        next_cur_reg   = cur_reg;
        if (cs_act) begin
            if (sclk_s && !sclk_prev && bit_cnt != 5'(FRAME_BITS)) begin
                next_shift_reg = {shift_reg[14:0], sdi_s};
                next_bit_cnt   = bit_cnt + 5'h01;
            end
        end else begin
            next_bit_cnt = 5'h00;
            if (commit) begin
                case (shift_reg[15:8])
                    ADDR_OUTPUT_ENABLE:  next_en_reg  = shift_reg[7:0];
                    ADDR_FLASH_TIMING:   next_tm_reg  = shift_reg[7:0];
                    ADDR_CURRENT_SELECT: next_cur_reg = shift_reg[7:0];
                    default: ;
                endcase
            end
        end
        if (pin_reset) begin
            next_en_reg  = OUTPUT_ENABLE_RST;
            next_tm_reg  = FLASH_TIMING_RST;
            next_cur_reg = CURRENT_SELECT_RST;
            next_bit_cnt = 5'h00;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            shift_reg <= 16'h0000;
            bit_cnt   <= 5'h00;
            sclk_prev <= 1'b0;
            cs_prev   <= 1'b0;
            en_reg    <= OUTPUT_ENABLE_RST;
            tm_reg    <= FLASH_TIMING_RST;
            cur_reg   <= CURRENT_SELECT_RST;
        end else begin
            shift_reg <= next_shift_reg;
            bit_cnt   <= next_bit_cnt;
            sclk_prev <= next_sclk_prev;
            cs_prev   <= next_cs_prev;
            en_reg    <= next_en_reg;
            tm_reg    <= next_tm_reg;
            cur_reg   <= next_cur_reg;
        end
    end

    // Enable selection
    logic        flash_req;
    logic        torch_req;
    logic        timer_on;
    logic [10:0] delay_ms;
    logic [10:0] on_limit_ms;

    assign torch_req   = mode_s ? selt_s : en_reg[EN_TORCH_BIT];
    assign flash_req   = mode_s ? rstf_s : en_reg[EN_FLASH_BIT];
    assign timer_on    = tm_reg[TM_MODE_BIT];
    assign delay_ms    = 11'(tm_reg[TM_DELAY_LSB +: 3]) * DELAY_STEP_MS;
    assign on_limit_ms = mode_s ? DIRECT_LIMIT_MS : FLASH_ON_MS[tm_reg[TM_ON_LSB +: 3]];

    // Flash sequencer
    flash_state_t state;
    flash_state_t next_state;
    logic [10:0]  ms_cnt;
    logic [10:0]  next_ms_cnt;
    logic         mode_prev;
    logic         next_mode_prev;

    always_comb begin
        next_state     = state;
        next_ms_cnt    = ms_cnt;
        next_mode_prev = mode_s;
        if (mode_s != mode_prev) begin
            next_state  = FL_IDLE;
            next_ms_cnt = 11'h000;
        end else begin
            case (state)
                FL_IDLE: begin
                    if (flash_req) begin
                        next_ms_cnt = 11'h000;
                        if (mode_s || !timer_on || delay_ms == 11'h000)
                            next_state = FL_ON;
                        else
                            next_state = FL_DELAY;
                    end
                end
                FL_DELAY: begin
                    if (!flash_req) begin
                        next_state = FL_IDLE;
                    end else if (tb.ms_tick) begin
                        if (ms_cnt + 11'h001 >= delay_ms) begin
                            next_state  = FL_ON;
                            next_ms_cnt = 11'h000;
                        end else begin
                            next_ms_cnt = ms_cnt + 11'h001;
                        end
                    end
                end
                FL_ON: begin
                    if (!flash_req) begin
                        next_state = FL_IDLE;
                    end else if (tb.ms_tick) begin
                        if (ms_cnt + 11'h001 >= on_limit_ms)
                            next_state = FL_DONE;
                        else
                            next_ms_cnt = ms_cnt + 11'h001;
                    end
                end
                FL_DONE: begin
                    if (!flash_req)
                        next_state = FL_IDLE;
                end
                default: next_state = FL_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state     <= FL_IDLE;
            ms_cnt    <= 11'h000;
            mode_prev <= 1'b0;
        end else begin
            state     <= next_state;
            ms_cnt    <= next_ms_cnt;
            mode_prev <= next_mode_prev;
        end
    end

    // Driver outputs, current codes and soft current limiter
    logic       next_torch_on;
    logic       next_flash_on;
    logic [1:0] next_torch_code;
    logic [1:0] next_flash_code;
    logic       next_boost;
    logic       next_active;
    logic       demand;
    logic [9:0] ss_cnt;
    logic [9:0] next_ss_cnt;
    logic [2:0] next_step;

    always_comb begin
        next_torch_on   = torch_req && !hot_s;
        next_flash_on   = (state == FL_ON) && flash_req && !hot_s;
        next_torch_code = mode_s ? DIRECT_TORCH_CODE : cur_reg[CS_TORCH_LSB +: 2];
        if (mode_s)
            next_flash_code = DIRECT_FLASH_CODE;
        else if (cur_reg[CS_LIMIT_BIT])
            next_flash_code = LIMITED_FLASH_CODE;
        else
            next_flash_code = cur_reg[CS_FLASH_LSB +: 2];
        demand      = next_torch_on || next_flash_on;
        next_boost  = demand && !hiv_s && !open_s && !hot_s;
        next_active = !hot_s;
        next_ss_cnt = ss_cnt;
        if (!demand)
            next_ss_cnt = 10'h000;
        else if (tb.us_tick && ss_cnt < SS_NORMAL_US)
            next_ss_cnt = ss_cnt + 10'h001;
        if (next_ss_cnt < SS_STEP1_US)
            next_step = LIMIT_0A0;
        else if (next_ss_cnt < SS_STEP2_US)
            next_step = LIMIT_0A5;
        else if (next_ss_cnt < SS_STEP3_US)
            next_step = LIMIT_1A0;
        else if (next_ss_cnt < SS_NORMAL_US)
            next_step = LIMIT_1A5;
        else
            next_step = LIMIT_2A0;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            torch_driver_on_out     <= 1'b0;
            flash_driver_on_out     <= 1'b0;
            torch_code_out          <= 2'h0;
            flash_code_out          <= 2'h0;
            current_limit_step_out  <= LIMIT_0A0;
            boost_switch_enable_out <= 1'b0;
            device_active_out       <= 1'b0;
            ss_cnt                  <= 10'h000;
        end else begin
            torch_driver_on_out     <= next_torch_on;
            flash_driver_on_out     <= next_flash_on;
            torch_code_out          <= next_torch_code;
            flash_code_out          <= next_flash_code;
            current_limit_step_out  <= next_step;
            boost_switch_enable_out <= next_boost;
            device_active_out       <= next_active;
            ss_cnt                  <= next_ss_cnt;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_enter_delay;
        state == FL_IDLE ##1 state == FL_DELAY;
    endsequence

    sequence s_direct_expire;
        state == FL_ON && mode_s && mode_prev && flash_req && tb.ms_tick
            && ms_cnt == DIRECT_LIMIT_MS - 11'h001;
    endsequence

    chk_commit_store: assert property (commit && shift_reg[15:8] == ADDR_OUTPUT_ENABLE && !pin_reset
        |=> en_reg == $past(shift_reg[7:0]))
        else $error("enable register did not take committed data");

    chk_test_ignored: assert property ((commit && !pin_reset && (shift_reg[15:8] == ADDR_FACTORY_TEST_A
        || shift_reg[15:8] == ADDR_FACTORY_TEST_B)) |=> $stable(en_reg) && $stable(tm_reg) && $stable(cur_reg))
        else $error("test register write changed control state");

    chk_torch_follow: assert property (!mode_s && !hot_s |=> torch_driver_on_out == $past(en_reg[EN_TORCH_BIT]))
        else $error("torch output does not follow enable register");

    chk_direct_pins: assert property (mode_s && !hot_s |=> torch_driver_on_out == $past(selt_s))
        else $error("torch output does not follow torch pin");

    chk_delay_dark: assert property (s_enter_delay |=> !flash_driver_on_out [*2])
        else $error("flash lit during delay");

    chk_on_drives: assert property (state == FL_ON && flash_req && !hot_s |=> flash_driver_on_out)
        else $error("flash not driven in on state");

    chk_direct_cutoff: assert property (s_direct_expire |=> state == FL_DONE ##1 !flash_driver_on_out)
        else $error("direct flash not cut at 500 ms");

    chk_timeout_off: assert property (state == FL_DONE |=> !flash_driver_on_out)
        else $error("flash still on after timeout");

    chk_direct_codes: assert property (mode_s |=> torch_code_out == DIRECT_TORCH_CODE
        && flash_code_out == DIRECT_FLASH_CODE)
        else $error("direct mode current codes wrong");

    chk_power_cap: assert property (!mode_s && cur_reg[CS_LIMIT_BIT] |=> flash_code_out == LIMITED_FLASH_CODE)
        else $error("power limit did not cap flash code");

    chk_soft_step: assert property ((current_limit_step_out == LIMIT_2A0 |-> ss_cnt >= SS_NORMAL_US)
        and (current_limit_step_out == LIMIT_0A0 |-> ss_cnt < SS_STEP1_US))
        else $error("soft limiter step does not match elapsed time");

    chk_thermal_off: assert property (hot_s |=> !torch_driver_on_out && !flash_driver_on_out
        && !boost_switch_enable_out && !device_active_out)
        else $error("device active during over-temperature");

    chk_boost_stop: assert property (hiv_s || open_s |=> !boost_switch_enable_out)
        else $error("boost switching during over-voltage or open sense");

endmodule
`default_nettype wire

//--- flash_led_control_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_led_control_logic_tb;
    import flash_pkg::*;
    localparam int MS = 20;
    logic ref_clk_in = 1'b0;
    logic rst_in, hi_volt, open_det, thermal;
    wire  mode, rf, ct, sclk, sdata;
    logic torch, flash, boost, active;
    logic [1:0] tcode, fcode;
    logic [2:0] step;
    int n_errors, n_compared, n, t, d, o;
    int ss[4] = '{SS_STEP1_US, SS_STEP2_US, SS_STEP3_US, SS_NORMAL_US};
    logic [7:0] tm[3] = '{8'h40, 8'h7f, 8'h0b};
    always #10 ref_clk_in = ~ref_clk_in;
    serial_host serial_host_i (.clk_in(ref_clk_in), .mode_out(mode), .rst_flash_out(rf),
        .cs_torch_out(ct), .sclk_out(sclk), .sdata_out(sdata));
    flash_led_control_logic #(.TICK_CYCLES(2), .MS_TICKS(10)) flash_led_control_logic_i (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .interface_mode_select_in(mode),
        .reset_or_flash_pin_in(rf), .select_or_torch_pin_in(ct), .serial_clk_in(sclk),
        .serial_data_in(sdata), .overvoltage_sense_in(hi_volt), .open_sense_detect_in(open_det),
        .thermal_shutdown_in(thermal), .torch_driver_on_out(torch), .flash_driver_on_out(flash),
        .torch_code_out(tcode), .flash_code_out(fcode), .current_limit_step_out(step),
        .boost_switch_enable_out(boost), .device_active_out(active));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rng(input int v, input int lo, input int hi);
        n_compared++;
        if (v < lo || v > hi) begin
            n_errors++;
            $display("CHECK FAILED at %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    function automatic logic [2:0] probe(input int which);
        case (which)
            0: probe = {2'b00, flash};
            1: probe = step;
            default: probe = {2'b00, torch};
        endcase
    endfunction
    task automatic wait_out(input int which, input logic [2:0] v, output int cnt);
        cnt = 0;
        while (probe(which) !== v && cnt < 25000) begin
            @(posedge ref_clk_in);
            cnt++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        serial_host_i.write(a, v);
    endtask
    task automatic results();
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge ref_clk_in);
        n_errors++;
        results();
    end
    initial begin
        {rst_in, hi_volt, open_det, thermal} = 4'h8;
        n_errors = 0;
        n_compared = 0;
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        chk({active, torch, flash}, 8'h04);
        wr(ADDR_CURRENT_SELECT, 8'h0c);
        chk(fcode, 8'h03);
        wr(ADDR_OUTPUT_ENABLE, 8'h01);
        wait_out(2, 3'h1, n);
        chk(step, LIMIT_0A0);
        t = 0;
        foreach (ss[i]) begin
            wait_out(1, 3'(i + 1), n);
            t += n;
            rng(t, ss[i] * 2 - 8, ss[i] * 2 + 8);
        end
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CURRENT_SELECT, 8'(c * 5));
            chk({tcode, fcode}, {4'h0, 2'(c), 2'(c)});
        end
        wr(ADDR_CURRENT_SELECT, 8'h1f);
        chk({tcode, fcode}, {4'h0, 2'h3, LIMITED_FLASH_CODE});
        wr(8'h00, 8'h00);
        chk({boost, torch}, 8'h03);
        for (int k = 0; k < 2; k++) begin
            {open_det, hi_volt} <= 2'(k + 1);
            repeat (6) @(posedge ref_clk_in);
            chk(boost, 8'h00);
            {open_det, hi_volt} <= 2'h0;
            repeat (6) @(posedge ref_clk_in);
            chk(boost, 8'h01);
        end
        thermal <= 1'b1;
        repeat (6) @(posedge ref_clk_in);
        chk({active, torch, boost}, 8'h00);
        thermal <= 1'b0;
        repeat (6) @(posedge ref_clk_in);
        chk({active, torch}, 8'h03);
        wr(ADDR_CURRENT_SELECT, 8'h0c);
        wr(ADDR_OUTPUT_ENABLE, 8'h00);
        foreach (tm[k]) begin
            wr(ADDR_FLASH_TIMING, tm[k]);
            wr(ADDR_OUTPUT_ENABLE, 8'h02);
            d = tm[k][6] ? int'(tm[k][5:3]) * DELAY_STEP_MS : 0;
            wait_out(0, 3'h1, n);
            rng(n, d * MS - MS - 8, d * MS + 8);
            wait_out(0, 3'h0, n);
            o = FLASH_ON_MS[tm[k][2:0]];
            rng(n, o * MS - MS - 8, o * MS + 8);
            wr(ADDR_OUTPUT_ENABLE, 8'h00);
        end
        wr(ADDR_OUTPUT_ENABLE, 8'h03);
        chk({torch, flash}, 8'h03);
        serial_host_i.pins(1'b0, 1'b0, 1'b1);
        serial_host_i.pins(1'b0, 1'b1, 1'b1);
        chk({torch, flash}, 8'h00);
        serial_host_i.pins(1'b1, 1'b0, 1'b1);
        chk({torch, tcode}, {5'h0, 1'b1, DIRECT_TORCH_CODE});
        serial_host_i.pins(1'b1, 1'b1, 1'b1);
        chk({flash, fcode}, {5'h0, 1'b1, DIRECT_FLASH_CODE});
        wait_out(0, 3'h0, n);
        rng(n, DIRECT_LIMIT_MS * MS - MS - 14, DIRECT_LIMIT_MS * MS + 8);
        serial_host_i.pins(1'b0, 1'b1, 1'b1);
        results();
    end
endmodule
`default_nettype wire

//--- flash_pkg.sv
`default_nettype none
package flash_pkg;

    // Register addresses
    localparam logic [7:0] ADDR_OUTPUT_ENABLE  = 8'h01;
    localparam logic [7:0] ADDR_FLASH_TIMING   = 8'h02;
    localparam logic [7:0] ADDR_CURRENT_SELECT = 8'h03;
    localparam logic [7:0] ADDR_FACTORY_TEST_A = 8'h04;
    localparam logic [7:0] ADDR_FACTORY_TEST_B = 8'h05;

    // Field positions
    localparam int EN_TORCH_BIT  = 0;
    localparam int EN_FLASH_BIT  = 1;
    localparam int TM_ON_LSB     = 0;
    localparam int TM_DELAY_LSB  = 3;
    localparam int TM_MODE_BIT   = 6;
    localparam int CS_TORCH_LSB  = 0;
    localparam int CS_FLASH_LSB  = 2;
    localparam int CS_LIMIT_BIT  = 4;

    // Reset values
    localparam logic [7:0] OUTPUT_ENABLE_RST  = 8'h00;
    localparam logic [7:0] FLASH_TIMING_RST   = 8'h40;
    localparam logic [7:0] CURRENT_SELECT_RST = 8'h00;

    // Fixed current codes
    localparam logic [1:0] DIRECT_TORCH_CODE  = 2'h3;
    localparam logic [1:0] DIRECT_FLASH_CODE  = 2'h3;
    localparam logic [1:0] LIMITED_FLASH_CODE = 2'h0;

    // Serial frame
    localparam int FRAME_BITS = 16;

    // Timebase: one tick per microsecond
    localparam int CLK_HZ        = 50_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int US_PER_MS     = 1000;

    // Flash timing in milliseconds
    localparam logic [10:0] DELAY_STEP_MS   = 11'h005;
    localparam logic [10:0] DIRECT_LIMIT_MS = 11'h1f4;
    localparam logic [7:0][10:0] FLASH_ON_MS = {
        11'h3e8, 11'h320, 11'h258, 11'h190, 11'h0c8, 11'h096, 11'h064, 11'h032};

    // Soft current limiter steps in microseconds
    localparam logic [9:0] SS_STEP1_US  = 10'h1f4;
    localparam logic [9:0] SS_STEP2_US  = 10'h2bc;
    localparam logic [9:0] SS_STEP3_US  = 10'h320;
    localparam logic [9:0] SS_NORMAL_US = 10'h384;

    // Current limit levels: 0, 0.5, 1, 1.5, 2 A
    localparam logic [2:0] LIMIT_0A0 = 3'h0;
    localparam logic [2:0] LIMIT_0A5 = 3'h1;
    localparam logic [2:0] LIMIT_1A0 = 3'h2;
    localparam logic [2:0] LIMIT_1A5 = 3'h3;
    localparam logic [2:0] LIMIT_2A0 = 3'h4;

    typedef enum logic [1:0] {
        FL_IDLE  = 2'b00,
        FL_DELAY = 2'b01,
        FL_ON    = 2'b10,
        FL_DONE  = 2'b11
    } flash_state_t;

endpackage
`default_nettype wire

//--- serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input  wire logic clk_in,
    output var  logic mode_out,
    output var  logic rst_flash_out,
    output var  logic cs_torch_out,
    output var  logic sclk_out,
    output var  logic sdata_out
);
    initial begin
        mode_out      = 1'b0;
        rst_flash_out = 1'b1;
        cs_torch_out  = 1'b1;
        sclk_out      = 1'b0;
        sdata_out     = 1'b0;
    end
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Only addresses outside the test registers are ever sent
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        logic [15:0] frame;
        frame = {addr, data};
        cs_torch_out <= 1'b0;
        cycles(4);
        for (int i = 15; i >= 0; i--) begin
            sdata_out <= frame[i];
            sclk_out  <= 1'b0;
            cycles(4);
            sclk_out <= 1'b1;
            cycles(4);
        end
        sclk_out <= 1'b0;
        cycles(4);
        cs_torch_out <= 1'b1;
        sdata_out    <= ~frame[0];
        cycles(8);
    endtask
    task automatic pins(input logic mode, input logic rf, input logic ct);
        mode_out      <= mode;
        rst_flash_out <= rf;
        cs_torch_out  <= ct;
        cycles(6);
    endtask
endmodule
`default_nettype wire

//--- tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module tick_gen #(
    parameter int TICK_CYCLES = flash_pkg::TICK_CYCLES,
    parameter int MS_TICKS    = flash_pkg::US_PER_MS
) (
    input  wire logic    clk_in,
    input  wire logic    rst_in,
    timebase_if.source   tb
);
    import flash_pkg::*;

    logic [15:0] cyc_cnt;
    logic [15:0] next_cyc_cnt;
    logic [15:0] tick_cnt;
    logic [15:0] next_tick_cnt;
    logic        us_tick;
    logic        next_us_tick;
    logic        ms_tick;
    logic        next_ms_tick;

    // Free-running microsecond and millisecond ticks
    always_comb begin
        next_cyc_cnt  = cyc_cnt + 16'h0001;
        next_tick_cnt = tick_cnt;
        next_us_tick  = 1'b0;
        next_ms_tick  = 1'b0;
        if (cyc_cnt == 16'(TICK_CYCLES - 1)) begin
            next_cyc_cnt = 16'h0000;
            next_us_tick = 1'b1;
            if (tick_cnt == 16'(MS_TICKS - 1)) begin
                next_tick_cnt = 16'h0000;
                next_ms_tick  = 1'b1;
            end else begin
                next_tick_cnt = tick_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cyc_cnt  <= 16'h0000;
            tick_cnt <= 16'h0000;
            us_tick  <= 1'b0;
            ms_tick  <= 1'b0;
        end else begin
            cyc_cnt  <= next_cyc_cnt;
            tick_cnt <= next_tick_cnt;
            us_tick  <= next_us_tick;
            ms_tick  <= next_ms_tick;
        end
    end

    assign tb.us_tick = us_tick;
    assign tb.ms_tick = ms_tick;

endmodule
`default_nettype wire

//--- timebase_if.sv
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
    logic us_tick;
    logic ms_tick;
    modport source (output us_tick, output ms_tick);
    modport sink   (input us_tick, input ms_tick);
endinterface
`default_nettype wire
